// File: rtl/hub_device_config_low_bits.sv
// hub device configuration bits 7..0 with link low-power control and timeout override
`default_nettype none
module hub_device_config_low_bits
   import hub_cfg_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  nrst,
   input  wire hub_cfg_pkg::cfg_mode_t cfgMode,
   input  wire hub_cfg_pkg::cfg_write_t eepromWrite,
   input  wire hub_cfg_pkg::cfg_write_t smbusWrite,
   input  wire hub_cfg_pkg::link_evt_t linkEvt,
   input  wire logic                  u1u2EntryReq,
   input  wire logic [7:0]            hostTimeout,
   output logic [7:0]                 cfgReadData,
   output logic                       u1u2Allowed,
   output logic                       u1u2EntryGrant,
   output logic [7:0]                 downstreamTimeout,
   output logic                       gangedPower,
   output logic                       portPowerSwitchOff_n
);
   import hub_cfg_pkg::*;

   // ---------------------------------------------------------------
   // helper functions
   // ---------------------------------------------------------------
   // a write counts only from the source that owns the current mode
   function automatic logic sourceHit(
      input cfg_mode_t mode,
      input logic      eepromValid,
      input logic      smbusValid
   );
      logic hit;
      case (mode)
         CFG_SRC_I2C:   hit = eepromValid;
         CFG_SRC_SMBUS: hit = smbusValid;
         default:       hit = 1'b0;
      endcase
      return hit;
   endfunction

   // reserved bits read back fixed whatever a source puts on them
   function automatic logic [7:0] withReserved(input logic [7:0] raw);
      logic [7:0] merged;
      merged              = raw;
      merged[RSVD_HI_BIT] = RSVD_HI_VAL;
      merged[RSVD_LO_BIT] = RSVD_LO_VAL;
      return merged;
   endfunction

   // zero switches the link timer off, so the override must leave a zero alone
   function automatic logic [7:0] overrideTimeout(
      input logic       enable,
      input logic [7:0] host
   );
      logic [7:0] result;
      result = host;
      if (enable && host != TIMEOUT_ZERO) begin
         result = TIMEOUT_MAX;
      end
      return result;
   endfunction

   // ---------------------------------------------------------------
   // register storage
   // ---------------------------------------------------------------
   logic [7:0] cfg_q;
   logic       lpmLifted_q;
   logic       writeHit;
   logic [7:0] writeData;

   // eeprom loads only in I2C mode, host writes only in SMBus mode
   always_comb begin
      writeHit  = sourceHit(cfgMode, eepromWrite.valid, smbusWrite.valid);
      writeData = eepromWrite.data;
      if (cfgMode == CFG_SRC_SMBUS) begin
         writeData = smbusWrite.data;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cfg_q <= RESET_LOW_BITS;
      end else if (writeHit) begin
         cfg_q <= withReserved(writeData);
      end
   end

   // ---------------------------------------------------------------
   // forced-accept latch
   // ---------------------------------------------------------------
   // nrst doubles as power-on reset; a new packet in the disconnect cycle wins
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         lpmLifted_q <= 1'b0;
      end else if (linkEvt.forcedAcceptRx || linkEvt.forcedAcceptTx) begin
         lpmLifted_q <= 1'b1;
      end else if (linkEvt.upstreamDisconnect) begin
         lpmLifted_q <= 1'b0;
      end
   end

   always_comb begin
      u1u2Allowed    = !cfg_q[LPM_DIS_BIT] || lpmLifted_q;
      u1u2EntryGrant = u1u2EntryReq && u1u2Allowed;
   end

   // ---------------------------------------------------------------
   // outputs from flip-flops
   // ---------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         downstreamTimeout <= TIMEOUT_ZERO;
      end else begin
         downstreamTimeout <= overrideTimeout(cfg_q[TMO_OVR_BIT], hostTimeout);
      end
   end

   always_comb begin
      cfgReadData          = cfg_q;
      gangedPower          = cfg_q[GANGED_BIT];
      portPowerSwitchOff_n = cfg_q[PWR_SW_OFF_BIT];
   end

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   // entry gating
   a_grant_blocked: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_q[LPM_DIS_BIT] && !lpmLifted_q) |-> !u1u2EntryGrant)
      else $error("entry granted while low power disabled");

   a_enable_grants: assert property (@(posedge clk) disable iff (!nrst)
      (!cfg_q[LPM_DIS_BIT] && u1u2EntryReq) |-> u1u2EntryGrant)
      else $error("entry refused while low power enabled");

   a_disabled_denied: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_q[LPM_DIS_BIT] && !lpmLifted_q) |-> !u1u2Allowed)
      else $error("low power allowed while disabled");

   a_no_req_grant: assert property (@(posedge clk) disable iff (!nrst)
      !u1u2EntryReq |-> !u1u2EntryGrant)
      else $error("entry granted without a request");

   a_lifted_grants: assert property (@(posedge clk) disable iff (!nrst)
      (lpmLifted_q && u1u2EntryReq) |-> u1u2EntryGrant)
      else $error("entry refused after forced accept");

   // forced-accept latch
   a_lift_latch: assert property (@(posedge clk) disable iff (!nrst)
      (linkEvt.forcedAcceptRx || linkEvt.forcedAcceptTx) |=> u1u2Allowed)
      else $error("forced accept did not lift prohibition");

   a_lift_holds: assert property (@(posedge clk) disable iff (!nrst)
      (lpmLifted_q && !linkEvt.upstreamDisconnect) |=> lpmLifted_q)
      else $error("lift dropped without disconnect");

   a_disc_restore: assert property (@(posedge clk) disable iff (!nrst)
      (linkEvt.upstreamDisconnect && !linkEvt.forcedAcceptRx && !linkEvt.forcedAcceptTx)
      |=> !lpmLifted_q)
      else $error("disconnect did not restore prohibition");

   a_latch_only: assert property (@(posedge clk) disable iff (!nrst)
      (!lpmLifted_q && !linkEvt.forcedAcceptRx && !linkEvt.forcedAcceptTx)
      |=> !lpmLifted_q)
      else $error("prohibition lifted without forced accept");

   a_lift_survives: assert property (@(posedge clk) disable iff (!nrst)
      (lpmLifted_q && !linkEvt.upstreamDisconnect) |=> u1u2Allowed)
      else $error("lifted state lost while connected");

   // register writes
   a_eeprom_load: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_I2C && eepromWrite.valid)
      |=> cfg_q[LPM_DIS_BIT] == $past(eepromWrite.data[LPM_DIS_BIT]))
      else $error("eeprom value not loaded");

   a_eeprom_bits: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_I2C && eepromWrite.valid)
      |=> cfg_q[GANGED_BIT:TMO_OVR_BIT] == $past(eepromWrite.data[GANGED_BIT:TMO_OVR_BIT]))
      else $error("eeprom power bits not loaded");

   a_smbus_write: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_SMBUS && smbusWrite.valid)
      |=> cfg_q[LPM_DIS_BIT] == $past(smbusWrite.data[LPM_DIS_BIT])
      && cfg_q[GANGED_BIT:TMO_OVR_BIT] == $past(smbusWrite.data[GANGED_BIT:TMO_OVR_BIT]))
      else $error("host write not stored");

   a_upper_stored: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_SMBUS && smbusWrite.valid)
      |=> cfg_q[CFG_W-1:LPM_DIS_BIT+1] == $past(smbusWrite.data[CFG_W-1:LPM_DIS_BIT+1]))
      else $error("host write of upper bits not stored");

   a_smbus_ignored: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_I2C && !eepromWrite.valid) |=> $stable(cfg_q))
      else $error("config changed without a legal write");

   a_eeprom_ignored: assert property (@(posedge clk) disable iff (!nrst)
      (cfgMode == CFG_SRC_SMBUS && !smbusWrite.valid) |=> $stable(cfg_q))
      else $error("config changed without a host write");

   a_rsvd_fixed: assert property (@(posedge clk) disable iff (!nrst)
      cfg_q[RSVD_HI_BIT] == RSVD_HI_VAL && cfg_q[RSVD_LO_BIT] == RSVD_LO_VAL)
      else $error("reserved bits lost their fixed values");

   // timeout override
   a_timeout_ovr: assert property (@(posedge clk) disable iff (!nrst)
      (cfg_q[TMO_OVR_BIT] && hostTimeout != TIMEOUT_ZERO) |=> downstreamTimeout == TIMEOUT_MAX)
      else $error("override did not force max timeout");

   a_timeout_zero: assert property (@(posedge clk) disable iff (!nrst)
      (hostTimeout == TIMEOUT_ZERO) |=> downstreamTimeout == TIMEOUT_ZERO)
      else $error("zero timeout not kept");

   a_timeout_pass: assert property (@(posedge clk) disable iff (!nrst)
      !cfg_q[TMO_OVR_BIT] |=> downstreamTimeout == $past(hostTimeout))
      else $error("host timeout not passed through");
endmodule
`default_nettype wire

// File: rtl/hub_cfg_pkg.sv
// package: field positions, reset values and types for the hub device configuration low bits
`default_nettype none
package hub_cfg_pkg;
   localparam int          CFG_W          = 8;
   localparam int          LPM_DIS_BIT    = 5;
   localparam int          RSVD_HI_BIT    = 4;
   localparam int          GANGED_BIT     = 3;
   localparam int          PWR_SW_OFF_BIT = 2;
   localparam int          TMO_OVR_BIT    = 1;
   localparam int          RSVD_LO_BIT    = 0;
   localparam logic        RSVD_HI_VAL    = 1'h1;
   localparam logic        RSVD_LO_VAL    = 1'h0;
   localparam logic [7:0]  RESET_LOW_BITS = 8'h10;
   localparam logic [7:0]  TIMEOUT_MAX    = 8'hFF;
   localparam logic [7:0]  TIMEOUT_ZERO   = 8'h00;

   typedef enum logic [1:0] {
      CFG_SRC_I2C   = 2'h0,
      CFG_SRC_SMBUS = 2'h1
   } cfg_mode_t;

   // one configuration write, from the EEPROM loader or the SMBus slave
   typedef struct packed {
      logic       valid;
      logic [7:0] data;
   } cfg_write_t;

   // link power management events seen on the upstream side
   typedef struct packed {
      logic forcedAcceptRx;
      logic forcedAcceptTx;
      logic upstreamDisconnect;
   } link_evt_t;
endpackage
`default_nettype wire

// File: test/cfg_host.sv
// partner model: configuration source acting as serial EEPROM or SMBus host
`default_nettype none
module cfg_host
   import hub_cfg_pkg::*;
(
   input  wire logic               toSmbus,
   input  wire logic               wr,
   input  wire logic [7:0]         data,
   output var hub_cfg_pkg::cfg_write_t eepromWrite,
   output var hub_cfg_pkg::cfg_write_t smbusWrite
);
   timeunit 1ns;
   timeprecision 1ns;
   // idle byte is inverted so a stale value never passes for a write
   assign eepromWrite = '{wr & ~toSmbus, wr ? data : ~data};
   assign smbusWrite  = '{wr & toSmbus, wr ? data : ~data};
endmodule
`default_nettype wire

// File: test/testbench.sv
// testbench: random and directed traffic against the configuration low bits
`default_nettype none
`define CHK(nm, ex, ob) begin check_count++; if ((ex) !== (ob)) begin n_errors++; \
   $display("ERROR %s expected %h seen %h", nm, ex, ob); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   import hub_cfg_pkg::*;
   logic        clk = 0, nrst = 0, toSmbus = 0, wr = 0, req = 0, look = 0, lifted = 0;
   logic [7:0]  data = 8'h00, tmo = 8'h00, cfg = 8'h10, rd, dsTmo;
   logic        allowed, grant, ganged, swOff;
   logic [19:0] e;
   logic [19:0] expQ[$];
   logic [31:0] seed = 32'h00005D47;
   int          n_errors = 0, check_count = 0, cyc = 0;
   cfg_mode_t   mode = CFG_SRC_I2C;
   link_evt_t   evt = '0;
   cfg_write_t  eeW, smW;
   hub_device_config_low_bits i_hub_device_config_low_bits(.clk(clk), .nrst(nrst),
      .cfgMode(mode), .eepromWrite(eeW), .smbusWrite(smW), .linkEvt(evt),
      .u1u2EntryReq(req), .hostTimeout(tmo), .cfgReadData(rd), .u1u2Allowed(allowed),
      .u1u2EntryGrant(grant), .downstreamTimeout(dsTmo), .gangedPower(ganged),
      .portPowerSwitchOff_n(swOff));
   cfg_host i_cfg_host(.toSmbus(toSmbus), .wr(wr), .data(data), .eepromWrite(eeW),
      .smbusWrite(smW));
   initial forever #50 clk = ~clk;
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // one transfer: write, link event, request and timeout, then note the outcome
   task automatic step(input logic [31:0] r);
      @(posedge clk) #10;
      look = 0;
      mode = r[0] ? CFG_SRC_SMBUS : CFG_SRC_I2C;
      toSmbus = r[1];
      wr = r[2];
      data = r[23:16];
      req = r[6];
      evt = r[5:3] & {r[9], r[10], r[11]};
      tmo = r[7] ? 8'h00 : r[15:8];
      if (wr && toSmbus == r[0]) cfg = (data & 8'hEE) | 8'h10;
      if (evt.forcedAcceptRx | evt.forcedAcceptTx) lifted = 1;
      else if (evt.upstreamDisconnect) lifted = 0;
      @(posedge clk) #10;
      wr = 0;
      evt = '0;
      @(posedge clk) #10;
      expQ.push_back({cfg, ~cfg[5] | lifted, req & (~cfg[5] | lifted), cfg[3], cfg[2],
         (cfg[1] && tmo != 8'h00) ? 8'hFF : tmo});
      look = 1;
   endtask
   always @(negedge clk) begin
      if (look) begin
         e = expQ.pop_front();
         `CHK("cfgReadData", e[19:12], rd)
         `CHK("u1u2Allowed", e[11], allowed)
         `CHK("u1u2EntryGrant", e[10], grant)
         `CHK("gangedPower", e[9], ganged)
         `CHK("portPowerSwitchOff_n", e[8], swOff)
         `CHK("downstreamTimeout", e[7:0], dsTmo)
      end
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 2000) begin
         n_errors++;
         stop_test();
      end
   end
   initial begin
      repeat (5) @(posedge clk);
      #10 nrst = 1;
      // reset state, disable via SMBus, lift by packet, drop by disconnect
      step(32'h00000000);
      step(32'h00200047);
      step(32'h00000261);
      step(32'h00000849);
      $display("directed test done");
      repeat (60) step(rnd());
      $display("random test done");
      // second reset in mid-run must drop the lifted state
      step(32'h00000261);
      @(posedge clk) #10;
      look = 0;
      nrst = 0;
      cfg = 8'h10;
      lifted = 0;
      @(posedge clk) #10 nrst = 1;
      step(32'h00200047);
      repeat (40) step(rnd());
      $display("reset test done");
      @(posedge clk) #10 look = 0;
      stop_test();
   end
endmodule
`default_nettype wire
